// ---- hdl/iaf_flags.sv ----
// Overview of operation
// RQ1 - Receive mode drives stored acknowledge bit out
// RQ2 - Transmit mode loads acknowledge from receiver's answer
// RQ3 - General call in slave receive sets flag
// RQ4 - Data register access clears general call flag
// RQ5 - Read one then write zero clears flag
// RQ6 - Slave flag resets zero, data access clears
`timescale 1ns/1ps
`default_nettype none

module iaf_flags
    import iaf_pkg::*;
(
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Operating mode
    input  wire logic       xmit_mode,
    input  wire logic       slave_rx,
    // Bus events from the shifter
    input  wire logic       ack_slot,
    input  wire logic       ack_sample,
    input  wire logic       gc_detect,
    input  wire logic       sa_detect,
    // Data line, open drain
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // Software access
    input  wire iaf_sw_s    sw,
    output iaf_flags_s      flags
);

    // One flop per flag, so each concern has its own process and a single driver
    logic ack_ff;
    logic gc_ff;
    logic sa_ff;
    logic armed_ff;
    logic sda_oe_ff;
    logic sda_o_ff;

    // Events decoded from the inputs of the current cycle
    logic dr_clear;
    logic gc_set;
    logic sa_set;
    logic gc_sw_clear;
    logic tx_sample;

    // A data register access counts only in the direction the mode moves data;
    // a read while transmitting or a write while receiving leaves the flags alone
    function automatic logic dir_access(
        input logic tx,
        input logic wr,
        input logic rd
    );
        return (tx && wr) || (!tx && rd);
    endfunction

    // Address detections only count while the unit is a slave receiver
    function automatic logic rx_event(
        input logic detect,
        input logic rx
    );
        return detect && rx;
    endfunction

    // Set and clear sources, qualified here so the flag processes stay plain
    assign dr_clear    = dir_access(xmit_mode, sw.dr_wr, sw.dr_rd); // RQ4
    assign gc_set      = rx_event(gc_detect, slave_rx); // RQ3
    assign sa_set      = rx_event(sa_detect || gc_detect, slave_rx);
    assign gc_sw_clear = armed_ff && sw.gc_wr && !sw.gc_wdata; // RQ5
    assign tx_sample   = xmit_mode && ack_sample; // RQ2

    // Acknowledge bit: the sampled answer wins over a software write in the same cycle,
    // since the bus answer cannot be repeated while software can write again
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ack_ff <= ACK_RST;
        end else if (tx_sample) begin
            ack_ff <= sda_i; // RQ2
        end else if (sw.ack_wr) begin
            ack_ff <= sw.ack_wdata; // RQ1
        end
    end

    // General call flag: a detection in the clearing cycle is kept, so no call is lost
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            gc_ff <= GC_RST;
        end else if (gc_set) begin
            gc_ff <= 1'h1; // RQ3
        end else if (dr_clear || gc_sw_clear) begin
            gc_ff <= 1'h0; // RQ4 RQ5
        end
    end

    // Arm the software clear only on a read that saw a one; any write disarms it,
    // and so does the flag dropping by another route, so a stale read cannot clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            armed_ff <= 1'h0;
        end else if (sw.gc_wr || !gc_ff) begin
            armed_ff <= 1'h0;
        end else if (sw.gc_rd) begin
            armed_ff <= 1'h1; // RQ5
        end
    end

    // Slave address flag: a match in the clearing cycle wins over the access
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sa_ff <= SA_RST; // RQ6
        end else if (sa_set) begin
            sa_ff <= 1'h1;
        end else if (dr_clear) begin
            sa_ff <= 1'h0; // RQ6
        end
    end

    // Pull the line low in the slot only for an acknowledge; a one just releases it
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sda_oe_ff <= 1'h0;
        end else begin
            sda_oe_ff <= ack_slot && !xmit_mode && !ack_ff; // RQ1
        end
    end

    // Open-drain level; only the enable moves, the level sits in a flop like every output
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sda_o_ff <= SDA_LOW;
        end else begin
            sda_o_ff <= SDA_LOW; // RQ1
        end
    end

    // Outputs straight from the flops
    assign flags  = {ack_ff, gc_ff, sa_ff};
    assign sda_oe = sda_oe_ff;
    assign sda_o  = sda_o_ff;

    // Most checks below look one cycle ahead, sa_rise_a and arm_source_a one cycle back, matching the one-cycle lag of every flop;
    // all of them are idle while reset is applied

    // Receive acknowledge of zero pulls the line
    ack_drive_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ1
        (ack_slot && !xmit_mode && !ack_ff) |=> sda_oe)
        else $error("acknowledge not driven low");

    // Receive acknowledge of one or transmit mode leaves the line free
    ack_release_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ1
        (!ack_slot || xmit_mode || ack_ff) |=> !sda_oe)
        else $error("data line driven outside an acknowledge");

    // Software write lands when no answer is sampled in the same cycle
    ack_write_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ1
        (sw.ack_wr && !tx_sample) |=> (flags.ack == $past(sw.ack_wdata)))
        else $error("acknowledge write lost");

    // Without a transmit sample or a write the acknowledge bit holds
    ack_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ2
        (!tx_sample && !sw.ack_wr) |=> $stable(flags.ack))
        else $error("acknowledge bit changed without cause");

    // Transmit sample lands in the acknowledge bit
    ack_sample_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ2
        (xmit_mode && ack_sample) |=> (flags.ack == $past(sda_i)))
        else $error("acknowledge answer not captured");

    // General call in slave receive sets the flag
    gc_set_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ3
        (gc_detect && slave_rx) |=> flags.gc)
        else $error("general call not flagged");

    // Data register access clears the flag
    gc_dr_clear_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ4
        (!gc_set && ((xmit_mode && sw.dr_wr) || (!xmit_mode && sw.dr_rd))) |=> !flags.gc)
        else $error("general call flag not cleared by data access");

    // Read of one then write of zero clears
    gc_sw_clear_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ5
        (flags.gc && sw.gc_rd && !sw.gc_wr && !gc_set) ##1
        (sw.gc_wr && !sw.gc_wdata && !gc_set) |=> !flags.gc)
        else $error("read then write zero did not clear");

    // Write of zero without a prior read keeps the flag
    gc_keep_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ5
        (flags.gc && !armed_ff && !dr_clear) |=> flags.gc)
        else $error("general call flag lost without cause");

    // Slave flag clears on data access without a match in the same cycle
    sa_clear_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
        (!sa_set && dr_clear) |=> !flags.sa)
        else $error("slave address flag not cleared");

    // Slave flag never rises without a detection
    sa_rise_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
        $rose(flags.sa) |-> $past(sa_set))
        else $error("slave address flag set without match");

    // General call flag stays low without a detection in slave receive
    gc_quiet_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ3
        (!flags.gc && !gc_set) |=> !flags.gc)
        else $error("general call flag set without detection");

    // The clear is armed only by a read that saw a one, with no write alongside
    arm_source_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ5
        $rose(armed_ff) |-> $past(sw.gc_rd && flags.gc && !sw.gc_wr))
        else $error("software clear armed without a read of one");

    // Slave match in slave receive sets the flag
    sa_set_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
        sa_set |=> flags.sa)
        else $error("slave address match not flagged");

    // Slave flag holds until a data register access
    sa_keep_a: assert property (@(posedge ref_clk) disable iff (rst) // RQ6
        (flags.sa && !dr_clear) |=> flags.sa)
        else $error("slave address flag lost without cause");

endmodule

`default_nettype wire

// ---- hdl/iaf_pkg.sv ----
package iaf_pkg;

    // Flag reset values
    localparam logic ACK_RST = 1'h0;
    localparam logic GC_RST  = 1'h0;
    localparam logic SA_RST  = 1'h0;

    // Level that the data line is pulled to while an acknowledge is driven
    localparam logic SDA_LOW = 1'h0;

    // Software side strobes and write data, one clock wide each
    typedef struct packed {
        logic dr_wr;     // Write of bus_data_register
        logic dr_rd;     // Read of bus_data_register
        logic ack_wr;    // Write of the acknowledge bit
        logic ack_wdata; // Value written to the acknowledge bit
        logic gc_rd;     // Read of general_call_seen_flag
        logic gc_wr;     // Write of general_call_seen_flag
        logic gc_wdata;  // Value written to general_call_seen_flag
    } iaf_sw_s;

    // Flag state shown to software
    typedef struct packed {
        logic ack;       // Acknowledge bit
        logic gc;        // general_call_seen_flag
        logic sa;        // Slave address recognised
    } iaf_flags_s;

endpackage

// ---- verif/iaf_bus_peer.sv ----
`timescale 1ns/1ps
`default_nettype none

module iaf_bus_peer (
    // Peer control and device drive
    input  wire logic nack,
    input  wire logic dut_oe,
    // Shared data line
    output logic      sda
);
    // Pull-up wins only when nobody pulls low; peer low is an acknowledge
    assign sda = !(dut_oe || !nack);
endmodule

`default_nettype wire

// ---- verif/iaf_flags_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

module iaf_flags_tb;
    import iaf_pkg::*;
    logic       ref_clk, rst, xm, srx, slot, samp, gcd, sad, nack, v, sda_i;
    logic       sda_o, sda_oe;
    iaf_sw_s    sw;
    iaf_flags_s flags;
    int         fail_count, checks;

    iaf_flags i_dut (.ref_clk(ref_clk), .rst(rst), .xmit_mode(xm), .slave_rx(srx),
        .ack_slot(slot), .ack_sample(samp), .gc_detect(gcd), .sa_detect(sad),
        .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .sw(sw), .flags(flags));
    iaf_bus_peer i_peer (.nack(nack), .dut_oe(sda_oe), .sda(sda_i));

    // Clock source
    initial begin
        ref_clk = 1'h0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Enable the device must show after a slot: only a stored zero in receive pulls
    function automatic logic oe_exp(input logic tx, input logic ack_bit);
        return !tx && !ack_bit;
    endfunction

    // Wired line level: low when either side pulls, else the pull-up
    function automatic logic line_exp(input logic pulled, input logic peer_nack);
        return !pulled && peer_nack;
    endfunction

    task automatic chk(input logic seen, input logic exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: flag mismatch", $time);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // Strobe for one cycle, then let one quiet cycle pass so flags settle
    task automatic go(input logic [6:0] s, input logic [1:0] d, input logic p);
        sw = s;
        gcd = d[1];
        sad = d[0];
        samp = p;
        @(posedge ref_clk) #1;
        sw = '0;
        {gcd, sad, samp} = '0;
        @(posedge ref_clk) #1;
    endtask

    // Main sequence
    initial begin
        {xm, srx, slot, samp, gcd, sad, v, sw} = '0;
        nack = 1'h1;
        rst = 1'h1;
        void'($urandom(32'hfebd));
        repeat (6) @(posedge ref_clk);
        #1 rst = 1'h0;
        chk(|flags, 1'h0);
        chk(sda_oe, 1'h0);
        chk(sda_o, SDA_LOW);
        xm = 1'h1;
        repeat (4) begin
            nack = 1'($urandom);
            go(7'h00, 2'h0, 1'h1);
            chk(flags.ack, nack);
            // A slot in transmit mode must never make the device pull
            slot = 1'h1;
            @(posedge ref_clk) #1;
            slot = 1'h0;
            chk(sda_oe, oe_exp(1'h1, nack));
        end
        // Corner: sampled answer beats a software write of one in the same cycle
        nack = 1'h0;
        go({3'h1, 1'h1, 3'h0}, 2'h0, 1'h1);
        chk(flags.ack, 1'h0);
        nack = 1'h1;
        $display("transmit sample test done");
        xm = 1'h0;
        repeat (4) begin
            v = 1'($urandom);
            nack = 1'($urandom);
            // Sample pulse in receive mode must be ignored, the write lands
            go({3'h1, v, 3'h0}, 2'h0, 1'h1);
            chk(flags.ack, v);
            slot = 1'h1;
            @(posedge ref_clk) #1;
            slot = 1'h0;
            chk(sda_oe, oe_exp(1'h0, v));
            chk(sda_i, line_exp(oe_exp(1'h0, v), nack));
            @(posedge ref_clk) #1;
            chk(sda_oe, 1'h0);
        end
        nack = 1'h1;
        $display("receive ack test done");
        go(7'h00, 2'h2, 1'h0);
        chk(flags.gc, 1'h0);
        chk(flags.sa, 1'h0);
        srx = 1'h1;
        go(7'h00, 2'h2, 1'h0);
        chk(flags.gc, 1'h1);
        chk(flags.sa, 1'h1);
        go(7'h03, 2'h0, 1'h0);
        chk(flags.gc, 1'h1);
        go(7'h02, 2'h0, 1'h0);
        chk(flags.gc, 1'h1);
        go(7'h04, 2'h0, 1'h0);
        go(7'h02, 2'h0, 1'h0);
        chk(flags.gc, 1'h0);
        // Corner: a write of one between the read and the zero disarms the clear
        go(7'h00, 2'h2, 1'h0);
        go(7'h04, 2'h0, 1'h0);
        go(7'h03, 2'h0, 1'h0);
        go(7'h02, 2'h0, 1'h0);
        chk(flags.gc, 1'h1);
        $display("general call test done");
        // Access against the mode leaves the flags, access with it clears them
        for (int m = 0; m < 2; m++) begin
            xm = m[0];
            go(7'h00, 2'h2, 1'h0);
            go(m[0] ? 7'h20 : 7'h40, 2'h0, 1'h0);
            chk(flags.gc, 1'h1);
            chk(flags.sa, 1'h1);
            go(m[0] ? 7'h40 : 7'h20, 2'h0, 1'h0);
            chk(flags.gc, 1'h0);
            chk(flags.sa, 1'h0);
        end
        go(7'h00, 2'h1, 1'h0);
        chk(flags.sa, 1'h1);
        chk(flags.gc, 1'h0);
        $display("data clear test done");
        // Mid-run reset with every flag set
        go(7'h18, 2'h2, 1'h0);
        chk(&flags, 1'h1);
        rst = 1'h1;
        @(posedge ref_clk) #1;
        chk(|flags, 1'h0);
        rst = 1'h0;
        go(7'h00, 2'h0, 1'h0);
        chk(|flags, 1'h0);
        $display("reset test done");
        results();
    end

    // Watchdog: the sequence needs well under 3 us
    initial begin
        #20us;
        fail_count++;
        results();
    end
endmodule

`default_nettype wire
